// >>> core/feoc_pkg.sv
// constants for the flash erase / one-time program command engine
// assumes a 250 MHz core clock and a flash array model outside the block
package feoc_pkg;
  // command opcodes in parameter word 0, high byte
  localparam logic [7:0] CMD_OTP_PROG = 8'h07;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
  localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h0a;
  localparam logic [7:0] CMD_UNSECURE = 8'h0b;
  // final parameter index expected at launch
  localparam logic [2:0] IDX_OTP = 3'h5;
  localparam logic [2:0] IDX_ERASE_ALL = 3'h0;
  localparam logic [2:0] IDX_ADDR = 3'h1;
  // one-time field geometry: 8 phrases of 4 words = 64 bytes
  localparam int OTP_PHRASES = 8;
  localparam int OTP_WORDS = 4;
  localparam logic [15:0] OTP_MAX_INDEX = 16'h0007;
  // parameter word file depth
  localparam int PARAM_WORDS = 6;
  // register offsets on the plain register port
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_INDEX = 4'h1;
  localparam logic [3:0] OFS_PARAM = 4'h2;
  localparam logic [3:0] OFS_CONTROL = 4'h3;
  localparam logic [3:0] OFS_SECURITY = 4'h4;
  // status register bit positions
  localparam int ST_CCF = 7;
  localparam int ST_ACC = 5;
  localparam int ST_PV = 4;
  localparam int ST_VE = 1;
  localparam int ST_VU = 0;
  // control register bit positions
  localparam int CT_MODE_OK = 0;
  localparam int CT_PROT_ANY = 1;
  localparam int CT_PROT_SEL = 2;
  localparam int CT_ADDR_OK = 3;
  localparam int CT_IS_DFLASH = 4;
  // reset values
  localparam logic [7:0] STATUS_RST = 8'h80;
  localparam logic [7:0] CONTROL_RST = 8'h09;
  // flash operation time per phase
  localparam int OP_TIME_NS = 400;
  localparam int CLK_PERIOD_NS = 4;
  localparam int OP_CYCLES = OP_TIME_NS / CLK_PERIOD_NS;
  localparam int OPCNT_W = 8;
  typedef enum logic [1:0] {FEOC_OP_NONE, FEOC_OP_ERASE, FEOC_OP_PROG, FEOC_OP_READ} feoc_op_t;
endpackage

// >>> core/feoc_timer.sv
// phase timer: counts a fixed number of cycles after a start pulse
// assumes start only while idle
`timescale 1ns/1ps
module feoc_timer
  import feoc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic start_i,
  output logic done_o
);
  logic [OPCNT_W-1:0] cnt_reg;
  logic busy_reg;

  // load on start, pulse done when the count runs out
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_reg <= OPCNT_W'(OP_CYCLES - 1);
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (cnt_reg == '0) begin
          busy_reg <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 1'b1;
        end
      end
    end
  end
endmodule // feoc_timer

// >>> core/feoc_otp_store.sv
// one-time field storage: 8 phrases of 64 bits in flip-flops
// assumes write and erase are never asked together
`timescale 1ns/1ps
module feoc_otp_store
  import feoc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [2:0] idx_i,
  input wire logic wr_i,
  input wire logic [63:0] wdata_i,
  output logic [63:0] rdata_o
);
  logic [63:0] mem_reg [OTP_PHRASES];

  // per-phrase storage; erased state is all ones, restored only by reset, never by a write
  genvar g;
  for (g = 0; g < OTP_PHRASES; g++) begin : g_phrase
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        mem_reg[g] <= '1;
      end else if (ce_i && wr_i && idx_i == 3'(g)) begin
        mem_reg[g] <= mem_reg[g] & wdata_i; // programming only clears bits
      end
    end
  end

  // registered read keeps the output flop-driven
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '1;
    end else if (ce_i) begin
      rdata_o <= mem_reg[idx_i];
    end
  end
endmodule // feoc_otp_store

// >>> core/feoc_engine.sv
// flash command engine for one-time program, erase-all, block erase,
// sector erase and unsecure; register port plus array handshake
// assumes array status inputs are synchronous and valid on op done
`timescale 1ns/1ps
module feoc_engine
  import feoc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic verify_err_i,
  input wire logic verify_uncorr_i,
  output logic [1:0] array_op_o,
  output logic [6:0] array_addr_hi_o,
  output logic [15:0] array_addr_lo_o,
  output logic array_all_o,
  output logic array_sector_o,
  output logic block0_read_invalid_o,
  output logic secure_o,
  output logic command_complete_flag_o
);
  typedef enum logic [2:0] {S_IDLE, S_CHECK, S_ERASE, S_PROG, S_VERIFY, S_DONE} feoc_state_t;
  feoc_state_t state_reg;
  logic [15:0] command_param_words_reg [PARAM_WORDS];
  logic [2:0] command_param_index_reg;
  logic command_complete_flag_reg;
  logic access_error_flag_reg;
  logic protection_violation_flag_reg;
  logic verify_error_flag_reg;
  logic verify_uncorrectable_flag_reg;
  logic [7:0] control_reg;
  logic secure_reg;
  logic [7:0] cmd_reg;
  logic [2:0] otp_idx_reg;
  logic op_start_reg;
  logic otp_wr_reg;
  logic [1:0] array_op_reg;
  logic [15:0] rdata_reg;
  logic op_done;
  logic [63:0] otp_rdata;
  logic launch;
  logic [7:0] opc;
  logic acc_next;
  logic pv_next;
  logic [63:0] otp_wdata;

  assign opc = command_param_words_reg[0][15:8];
  // host launches by writing one to the completion bit while it is set
  assign launch = wr_i && addr_i == OFS_STATUS && wdata_i[ST_CCF] && command_complete_flag_reg;
  assign otp_wdata = {command_param_words_reg[2], command_param_words_reg[3],
                      command_param_words_reg[4], command_param_words_reg[5]};

  // launch checks: index, mode, phrase, address, alignment, protection
  // worked out before launch so a refused command never touches the array
  always_comb begin
    acc_next = 1'b0;
    pv_next = 1'b0;
    // a command outside its mode is refused whatever else it carries
    if (!control_reg[CT_MODE_OK]) begin
      acc_next = 1'b1;
    end
    unique case (opc)
      CMD_OTP_PROG: begin
        if (command_param_index_reg != IDX_OTP) begin
          acc_next = 1'b1;
        end
        // only phrases 0..7 exist; the used-phrase test waits for the read-back
        if (command_param_words_reg[1] > OTP_MAX_INDEX) begin
          acc_next = 1'b1;
        end
      end
      CMD_ERASE_ALL, CMD_UNSECURE: begin
        if (command_param_index_reg != IDX_ERASE_ALL) begin
          acc_next = 1'b1;
        end
        if (control_reg[CT_PROT_ANY]) begin
          pv_next = 1'b1;
        end
      end
      CMD_ERASE_BLOCK: begin
        if (command_param_index_reg != IDX_ADDR) begin
          acc_next = 1'b1;
        end
        if (!control_reg[CT_ADDR_OK]) begin
          acc_next = 1'b1;
        end
        // data flash needs word alignment, program flash a whole phrase
        if (control_reg[CT_IS_DFLASH] ? command_param_words_reg[1][0] != 1'b0
            : command_param_words_reg[1][2:0] != 3'h0) begin
          acc_next = 1'b1;
        end
        if (control_reg[CT_PROT_SEL]) begin
          pv_next = 1'b1;
        end
      end
      CMD_ERASE_SECTOR: begin
        if (command_param_index_reg != IDX_ADDR) begin
          acc_next = 1'b1;
        end
        if (!control_reg[CT_ADDR_OK]) begin
          acc_next = 1'b1;
        end
        if (command_param_words_reg[1][2:0] != 3'h0) begin
          acc_next = 1'b1;
        end
        if (control_reg[CT_PROT_SEL]) begin
          pv_next = 1'b1;
        end
      end
      // unknown opcodes are refused rather than silently ignored
      default: begin
        acc_next = 1'b1;
      end
    endcase
  end

  // command sequencer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= S_IDLE;
      cmd_reg <= 8'h00;
      otp_idx_reg <= 3'h0;
      op_start_reg <= 1'b0;
      otp_wr_reg <= 1'b0;
      array_op_reg <= FEOC_OP_NONE;
    end else if (ce_i) begin
      op_start_reg <= 1'b0;
      otp_wr_reg <= 1'b0;
      unique case (state_reg)
        S_IDLE: begin
          if (launch) begin
            cmd_reg <= opc;
            otp_idx_reg <= command_param_words_reg[1][2:0];
            if (acc_next || pv_next) begin
              state_reg <= S_DONE;
            end else if (opc == CMD_OTP_PROG) begin
              state_reg <= S_CHECK;
            end else begin
              state_reg <= S_ERASE;
              array_op_reg <= FEOC_OP_ERASE;
              op_start_reg <= 1'b1;
            end
          end
        end
        S_CHECK: begin
          // phrase still all ones counts as erased and may be written
          if (otp_rdata != '1) begin
            state_reg <= S_DONE;
          end else begin
            state_reg <= S_PROG;
            array_op_reg <= FEOC_OP_PROG;
            op_start_reg <= 1'b1;
            otp_wr_reg <= 1'b1;
          end
        end
        S_ERASE, S_PROG: begin
          if (op_done) begin
            state_reg <= S_VERIFY;
            array_op_reg <= FEOC_OP_READ;
            op_start_reg <= 1'b1;
          end
        end
        S_VERIFY: begin
          if (op_done) begin
            state_reg <= S_DONE;
            array_op_reg <= FEOC_OP_NONE;
          end
        end
        S_DONE: state_reg <= S_IDLE;
        // two state codes are unused; fall back to idle rather than hang
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // completion flag: cleared by launch, set on finish
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      command_complete_flag_reg <= 1'b1;
    end else if (ce_i) begin
      if (launch) begin
        command_complete_flag_reg <= 1'b0;
      end else if (state_reg == S_DONE) begin
        command_complete_flag_reg <= 1'b1;
      end
    end
  end

  // error flags: cleared at launch, set by checks and verify; write one also clears the access and protection flags
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      access_error_flag_reg <= 1'b0;
      protection_violation_flag_reg <= 1'b0;
      verify_error_flag_reg <= 1'b0;
      verify_uncorrectable_flag_reg <= 1'b0;
    end else if (ce_i) begin
      if (launch) begin
        access_error_flag_reg <= acc_next;
        protection_violation_flag_reg <= pv_next;
        verify_error_flag_reg <= 1'b0;
        verify_uncorrectable_flag_reg <= 1'b0;
      end else begin
        if (wr_i && addr_i == OFS_STATUS && wdata_i[ST_ACC]) begin
          access_error_flag_reg <= 1'b0;
        end
        if (wr_i && addr_i == OFS_STATUS && wdata_i[ST_PV]) begin
          protection_violation_flag_reg <= 1'b0;
        end
        // set wins over the clear in the same cycle
        if (state_reg == S_CHECK && otp_rdata != '1) access_error_flag_reg <= 1'b1;
        if (state_reg == S_VERIFY && op_done) begin
          verify_error_flag_reg <= verify_err_i;
          verify_uncorrectable_flag_reg <= verify_uncorr_i;
        end
      end
    end
  end

  // security released only by a mass-erase verify with no verify error; the uncorrectable flag is not looked at
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      secure_reg <= 1'b1;
    end else if (ce_i) begin
      if (wr_i && addr_i == OFS_SECURITY && wdata_i[0]) secure_reg <= 1'b1;
      else if (state_reg == S_VERIFY && op_done && !verify_err_i
               && (cmd_reg == CMD_ERASE_ALL || cmd_reg == CMD_UNSECURE)) begin
        secure_reg <= 1'b0;
      end
    end
  end

  // parameter index and words; writes ignored while busy, host must not write then
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      command_param_index_reg <= 3'h0;
      control_reg <= CONTROL_RST;
      for (int i = 0; i < PARAM_WORDS; i++) command_param_words_reg[i] <= 16'h0000;
    end else if (ce_i && wr_i && command_complete_flag_reg) begin
      if (addr_i == OFS_INDEX) command_param_index_reg <= wdata_i[2:0];
      if (addr_i == OFS_CONTROL) control_reg <= wdata_i[7:0];
      if (addr_i == OFS_PARAM && command_param_index_reg < 3'(PARAM_WORDS)) begin
        command_param_words_reg[command_param_index_reg] <= wdata_i;
      end
    end
  end

  // register reads, data one cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 16'h0000;
    end else if (ce_i) begin
      rdata_reg <= 16'h0000;
      if (rd_i) begin
        unique case (addr_i)
          OFS_STATUS: rdata_reg <= {8'h00, command_complete_flag_reg, 1'b0, access_error_flag_reg,
                                    protection_violation_flag_reg, 2'b00, verify_error_flag_reg,
                                    verify_uncorrectable_flag_reg};
          OFS_INDEX: rdata_reg <= {13'h0000, command_param_index_reg};
          OFS_PARAM: rdata_reg <= (command_param_index_reg < 3'(PARAM_WORDS))
                                  ? command_param_words_reg[command_param_index_reg] : 16'h0000;
          OFS_CONTROL: rdata_reg <= {8'h00, control_reg};
          OFS_SECURITY: rdata_reg <= {15'h0000, secure_reg};
          default: rdata_reg <= 16'h0000;
        endcase
      end
    end
  end

  assign rdata_o = rdata_reg;
  assign array_op_o = array_op_reg;
  assign secure_o = secure_reg;
  assign command_complete_flag_o = command_complete_flag_reg;

  // array target outputs, held for the whole command
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      array_addr_hi_o <= 7'h00;
      array_addr_lo_o <= 16'h0000;
      array_all_o <= 1'b0;
      array_sector_o <= 1'b0;
      block0_read_invalid_o <= 1'b0;
    end else if (ce_i) begin
      if (state_reg == S_IDLE && launch) begin
        array_addr_hi_o <= command_param_words_reg[0][6:0];
        array_addr_lo_o <= command_param_words_reg[1];
        array_all_o <= opc == CMD_ERASE_ALL || opc == CMD_UNSECURE;
        array_sector_o <= opc == CMD_ERASE_SECTOR;
      end
      // block 0 reads corrupt while the one-time field is busy
      block0_read_invalid_o <= cmd_reg == CMD_OTP_PROG && (state_reg == S_CHECK
                               || state_reg == S_PROG || state_reg == S_VERIFY);
    end
  end

  feoc_timer u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .start_i(op_start_reg),
    .done_o(op_done)
  );

  feoc_otp_store u_otp (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .idx_i(state_reg == S_IDLE ? command_param_words_reg[1][2:0] : otp_idx_reg),
    .wr_i(otp_wr_reg),
    .wdata_i(otp_wdata),
    .rdata_o(otp_rdata)
  );
endmodule // feoc_engine

// >>> bench/feoc_array_model.sv
// flash array stand-in: answers each verify phase with pass or a commanded failure
// assumes the engine samples the results while the verify phase is showing
`timescale 1ns/1ps
module feoc_array_model
  import feoc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] array_op_i,
  input wire logic [1:0] fail_i,
  output logic verify_err_o,
  output logic verify_uncorr_o
);
  logic [1:0] noise_reg;
  // outside verify the lines mean nothing, so they wander instead of holding
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      noise_reg <= 2'h1;
    end else begin
      noise_reg <= ~noise_reg;
    end
  end
  // read-back result of the verify phase
  assign verify_err_o = (array_op_i == 2'h3) ? fail_i[1] : noise_reg[1];
  assign verify_uncorr_o = (array_op_i == 2'h3) ? fail_i[0] : noise_reg[0];
endmodule // feoc_array_model

// >>> bench/feoc_engine_monitor.sv
// concurrent checks on the command engine ports
// assumes it is bound into every engine instance
`timescale 1ns/1ps
module feoc_engine_monitor
  import feoc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input logic [1:0] array_op_o,
  input logic array_all_o,
  input logic array_sector_o,
  input logic [15:0] array_addr_lo_o,
  input logic block0_read_invalid_o,
  input logic secure_o,
  input logic command_complete_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // launch and phase ordering
  launch_clear_a: assert property (
    wr_i && ce_i && addr_i == OFS_STATUS && wdata_i[ST_CCF] && command_complete_flag_o
    |-> ##[1:2] !command_complete_flag_o) else $error("launch left completion set");
  busy_phase_a: assert property (
    array_op_o != 2'h0 |-> !command_complete_flag_o) else $error("phase active while complete");
  done_verify_a: assert property (
    $past(array_op_o) == 2'h3 && array_op_o == 2'h0 |-> ##[0:1] command_complete_flag_o)
    else $error("no completion after verify");
  erase_hold_a: assert property (
    $rose(array_op_o == 2'h1) |-> (array_op_o == 2'h1) [*8]) else $error("erase phase cut short");
  verify_next_a: assert property (
    $past(array_op_o) == 2'h1 && array_op_o != 2'h1 |-> array_op_o == 2'h3) else $error("erase not verified");
  otp_invalid_a: assert property (
    array_op_o == 2'h2 |-> block0_read_invalid_o) else $error("block 0 readable during program");
  otp_no_erase_a: assert property (
    block0_read_invalid_o |-> array_op_o != 2'h1) else $error("erase during one-time program");
  sector_scope_a: assert property (
    array_sector_o && array_op_o == 2'h1 |-> !array_all_o && array_addr_lo_o[2:0] == 3'h0)
    else $error("sector erase on bad target");
  secure_drop_a: assert property (
    $fell(secure_o) |-> $past(array_all_o) ##[0:1] command_complete_flag_o) else $error("bad security release");
endmodule // feoc_engine_monitor

bind feoc_engine feoc_engine_monitor u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .array_op_o(array_op_o), .array_all_o(array_all_o),
  .array_sector_o(array_sector_o), .array_addr_lo_o(array_addr_lo_o),
  .block0_read_invalid_o(block0_read_invalid_o), .secure_o(secure_o),
  .command_complete_flag_o(command_complete_flag_o));

// >>> bench/feoc_engine_tb.sv
// self-checking bench: register port driver, read-data checker, array model
// assumes ce held high except in the frozen-enable check; reads noted in a queue and compared when data stands
`timescale 1ns/1ps
module feoc_engine_tb;
  import feoc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rd_d = 1'b0;
  logic inv = 1'b0;
  logic ce = 1'b1;
  logic [6:0] ahi;
  logic [15:0] alo;
  logic [1:0] fail = 2'h0;
  logic [15:0] rdata_o;
  logic [1:0] array_op_o;
  logic verify_err_i, verify_uncorr_i, secure_o, command_complete_flag_o, block0_read_invalid_o;
  logic [15:0] pw [6];
  logic [31:0] exp_q [$];
  logic [31:0] seed = 32'hdab33c72;
  logic [7:0] opc [5] = '{CMD_OTP_PROG, CMD_ERASE_ALL, CMD_ERASE_BLOCK, CMD_ERASE_SECTOR, CMD_UNSECURE};
  logic [2:0] lix [5] = '{IDX_OTP, IDX_ERASE_ALL, IDX_ADDR, IDX_ADDR, IDX_ERASE_ALL};
  int bad_count = 0;
  int comparisons = 0;
  int n;

  always #2 clk_i = ~clk_i;

  feoc_engine dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .verify_err_i(verify_err_i), .verify_uncorr_i(verify_uncorr_i),
    .array_op_o(array_op_o), .array_addr_hi_o(ahi), .array_addr_lo_o(alo), .array_all_o(), .array_sector_o(),
    .block0_read_invalid_o(block0_read_invalid_o), .secure_o(secure_o),
    .command_complete_flag_o(command_complete_flag_o));
  feoc_array_model u_array (.clk_i(clk_i), .rst_n_i(rst_n_i), .array_op_i(array_op_o), .fail_i(fail),
    .verify_err_o(verify_err_i), .verify_uncorr_o(verify_uncorr_i));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge clk_i) rd_d <= rd_i;
  always @(negedge clk_i) begin
    if (rd_d && exp_q.size() > 0) begin
      chk("read data", exp_q[0][15:0], rdata_o & exp_q[0][31:16]);
      void'(exp_q.pop_front());
    end
  end
  // strobes stay up between tasks so no signal is assigned twice at one edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    exp_q.push_back({m, e});
    addr_i <= a;
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
  endtask
  function automatic logic [15:0] st(input logic a, input logic p, input logic v, input logic u);
    return {8'h00, 1'b1, 1'b0, a, p, 2'b00, v, u};
  endfunction
  task automatic setw(input logic [7:0] op, input logic [15:0] w1);
    pw[0] = {op, 8'h01};
    pw[1] = w1;
    for (int i = 2; i < 6; i++) pw[i] = 16'($random(seed));
  endtask
  // load words, launch, wait for completion, then note the expected status
  task automatic run(input int last, input logic [2:0] ix, input logic [15:0] s);
    for (int i = 0; i <= last; i++) begin
      wr(OFS_INDEX, 16'(i));
      wr(OFS_PARAM, pw[i]);
    end
    wr(OFS_INDEX, {13'h0000, ix});
    wr(OFS_STATUS, 16'h0080);
    wr_i <= 1'b0; // no register writes while busy
    n = 0;
    inv = 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    while (command_complete_flag_o !== 1'b1 && n < 1000) begin
      if (block0_read_invalid_o === 1'b1) inv = 1'b1;
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
    chk("completion", 16'h0001, 16'(n < 1000));
    rd(OFS_STATUS, 16'h00b3, s);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    $display("ERROR watchdog expected finish seen hang");
    summarize();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(OFS_STATUS, 16'h00b3, st(0, 0, 0, 0));
    rd(OFS_CONTROL, 16'h001f, {8'h00, CONTROL_RST});
    rd(OFS_SECURITY, 16'h0001, 16'h0001);
    // each command outside its mode, then with a wrong final index
    for (int k = 0; k < 10; k++) begin
      wr(OFS_CONTROL, (k < 5) ? 16'h0008 : 16'h0009);
      setw(opc[k % 5], 16'h0000);
      run(lix[k % 5], (k < 5) ? lix[k % 5] : lix[k % 5] ^ 3'h1, st(1, 0, 0, 0));
      chk("fast error", 16'h0001, 16'(n <= 3));
    end
    // mass commands look at any protection, block and sector at the target
    for (int k = 1; k < 5; k++) begin
      wr(OFS_CONTROL, (k == 1 || k == 4) ? 16'h000b : 16'h000d);
      setw(opc[k], 16'h0000);
      run(lix[k], lix[k], st(0, 1, 0, 0));
      chk("fast error", 16'h0001, 16'(n <= 3));
    end
    // write-one clears both launch error flags without launching
    wr(OFS_STATUS, 16'h0030);
    rd(OFS_STATUS, 16'h00b3, st(0, 0, 0, 0));
    wr(OFS_CONTROL, 16'h0001);
    setw(CMD_ERASE_BLOCK, 16'h0000);
    run(1, IDX_ADDR, st(1, 0, 0, 0));
    wr(OFS_CONTROL, 16'h0009);
    setw(CMD_ERASE_SECTOR, 16'h0104);
    run(1, IDX_ADDR, st(1, 0, 0, 0));
    setw(CMD_ERASE_BLOCK, 16'h0002);
    run(1, IDX_ADDR, st(1, 0, 0, 0));
    fail <= 2'h2;
    setw(CMD_ERASE_SECTOR, 16'h0108);
    run(1, IDX_ADDR, st(0, 0, 1, 0));
    chk("target high", 16'h0001, {9'h000, ahi});
    chk("target low", 16'h0108, alo);
    wr(OFS_CONTROL, 16'h0019);
    setw(CMD_ERASE_BLOCK, 16'h0001);
    run(1, IDX_ADDR, st(1, 0, 0, 0));
    fail <= 2'h0;
    setw(CMD_ERASE_BLOCK, 16'h0002);
    run(1, IDX_ADDR, st(0, 0, 0, 0));
    // failed mass verify keeps security, passing ones release it
    wr(OFS_CONTROL, 16'h0009);
    fail <= 2'h3;
    setw(CMD_UNSECURE, 16'h0000);
    run(0, IDX_ERASE_ALL, st(0, 0, 1, 1));
    rd(OFS_SECURITY, 16'h0001, 16'h0001);
    fail <= 2'h0;
    for (int k = 1; k < 5; k += 3) begin
      setw(opc[k], 16'h0000);
      run(0, IDX_ERASE_ALL, st(0, 0, 0, 0));
      rd(OFS_SECURITY, 16'h0001, 16'h0000);
      wr(OFS_SECURITY, 16'h0001);
    end
    // one-time field: first write, repeat refused, index past the last phrase
    setw(CMD_OTP_PROG, 16'h0003);
    run(5, IDX_OTP, st(0, 0, 0, 0));
    chk("block0 invalid", 16'h0001, {15'h0000, inv});
    setw(CMD_OTP_PROG, 16'h0003);
    run(5, IDX_OTP, st(1, 0, 0, 0));
    setw(CMD_OTP_PROG, 16'h0008);
    run(5, IDX_OTP, st(1, 0, 0, 0));
    setw(CMD_OTP_PROG, 16'h0007);
    run(5, IDX_OTP, st(0, 0, 0, 0));
    // an all-ones phrase still counts as blank
    setw(CMD_OTP_PROG, 16'h0006);
    for (int i = 2; i < 6; i++) pw[i] = 16'hffff;
    run(5, IDX_OTP, st(0, 0, 0, 0));
    setw(CMD_OTP_PROG, 16'h0006);
    run(5, IDX_OTP, st(0, 0, 0, 0));
    // frozen clock enable: a write in that cycle must not land
    ce <= 1'b0;
    wr(OFS_INDEX, 16'h0003);
    ce <= 1'b1;
    rd(OFS_INDEX, 16'h0007, {13'h0000, IDX_OTP});
    rd_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    summarize();
  end
endmodule // feoc_engine_tb
